// ==== logic/dmaa_pkg.sv ====
// Package with constants and types for the debug memory access alignment block.
package dmaa_pkg;

	// ----------------------------------------------------------------
	// Access sizes and commands
	// ----------------------------------------------------------------
	localparam logic [1:0] DMAA_SIZE_8  = 2'h0;
	localparam logic [1:0] DMAA_SIZE_16 = 2'h1;
	localparam logic [1:0] DMAA_SIZE_32 = 2'h2;

	localparam logic [2:0] DMAA_CMD_READ   = 3'h0; // Addressed single read.
	localparam logic [2:0] DMAA_CMD_WRITE  = 3'h1; // Addressed single write.
	localparam logic [2:0] DMAA_CMD_DUMP   = 3'h2; // Block read, address from last access.
	localparam logic [2:0] DMAA_CMD_FILL   = 3'h3; // Block write, address from last access.
	localparam logic [2:0] DMAA_CMD_TRACE  = 3'h4; // Trace readout command.

	// ----------------------------------------------------------------
	// Reset values, fixed answers, lane mask and state encoding
	// ----------------------------------------------------------------
	localparam logic [7:0]  DMAA_TRACE_VALUE = 8'h00;
	localparam logic [23:0] DMAA_ADDR_RESET  = 24'h000000;
	localparam logic [1:0]  DMAA_LANE_MASK   = 2'h3;

	typedef enum logic [1:0] {
		DMAA_IDLE = 2'b01,
		DMAA_DONE = 2'b10
	} dmaa_state_t;

endpackage : dmaa_pkg

// ==== logic/dmaa_align.sv ====
// Address sequencing and byte-lane alignment for debug port memory commands.

// Functional notes
// - Trace readout command answers with an all-zero byte.
// - Block commands add previous size to previous address.
// - Misaligned longword clears address bits one and zero.
// - Realigned word: next block address counts from original address.
// - Word at lane three is moved to the two upper lanes.
// - Repeated byte accesses from word realignment are allowed, unflagged.
// - Lanes follow address bits; longword MSB sits in lane zero.
module dmaa_align
	import dmaa_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	input  wire logic              cmd_valid,
	input  wire logic [2:0]        cmd_code,
	input  wire logic [1:0]        cmd_size,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [31:0]       cmd_wdata,
	input  wire logic [31:0]       mem_rdata,
	output logic                   mem_req,
	output logic                   mem_we,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [3:0]             mem_lane_en,
	output logic [31:0]            mem_wdata,
	output logic                   rsp_valid,
	output logic [31:0]            rsp_data,
	output logic [ADDR_W-1:0]      rsp_addr
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		dmaa_state_t       state;
		logic [ADDR_W-1:0] last_addr;  // Address used for the next increment.
		logic [1:0]        last_size;
		logic              mem_req;
		logic              mem_we;
		logic [ADDR_W-1:0] mem_addr;
		logic [3:0]        mem_lane_en;
		logic [31:0]       mem_wdata;
		logic [1:0]        rd_lane;    // Low address bits of the pending read.
		logic [1:0]        rd_size;
		logic              rsp_valid;
		logic [31:0]       rsp_data;
		logic [ADDR_W-1:0] rsp_addr;
	} dmaa_regs_t;

	dmaa_regs_t cur;
	dmaa_regs_t next_cur;

	// Size in bytes of an access code.
	function automatic logic [ADDR_W-1:0] dmaa_bytes(input logic [1:0] sz);
		logic [ADDR_W-1:0] n;
		n = ADDR_W'(1);
		if (sz == DMAA_SIZE_16) begin
			n = ADDR_W'(2);
		end else if (sz == DMAA_SIZE_32) begin
			n = ADDR_W'(4);
		end
		return n;
	endfunction : dmaa_bytes

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Memory is assumed to answer mem_rdata in the same cycle as mem_req.
	always_comb begin
		logic [ADDR_W-1:0] orig;
		logic [ADDR_W-1:0] eff;
		logic [1:0]        lo;
		logic [3:0]        lanes;
		logic [31:0]       wd;
		logic [31:0]       rd;
		orig = '0;
		eff = '0;
		lo = 2'h0;
		lanes = 4'h0;
		wd = '0;
		rd = '0;
		next_cur = cur;
		next_cur.mem_req = 1'b0;
		next_cur.rsp_valid = 1'b0;
		case (cur.state)
			DMAA_IDLE: begin
				if (cmd_valid) begin
					if (cmd_code == DMAA_CMD_TRACE) begin
						next_cur.rsp_valid = 1'b1;
						next_cur.rsp_data = {24'h000000, DMAA_TRACE_VALUE};
					end else if (cmd_code <= DMAA_CMD_FILL) begin
						if (cmd_code == DMAA_CMD_DUMP || cmd_code == DMAA_CMD_FILL) begin
							orig = cur.last_addr + dmaa_bytes(cur.last_size);
						end else begin
							orig = cmd_addr;
						end
						eff = orig;
						lo = orig[1:0];
						case (cmd_size)
							DMAA_SIZE_32: begin
								eff[1:0] = 2'h0;
								lanes = 4'hf;
								wd = cmd_wdata;
							end
							DMAA_SIZE_16: begin
								if (lo == DMAA_LANE_MASK) begin
									eff[1:0] = 2'h2;
								end
								lanes = 4'h3 << eff[1:0];
								wd = 32'(cmd_wdata[15:0]) << (5'(2'h2 - eff[1:0]) << 3);
							end
							default: begin
								lanes = 4'h1 << lo;
								wd = 32'(cmd_wdata[7:0]) << (5'(2'h3 - lo) << 3);
							end
						endcase
						next_cur.last_addr = (cmd_size == DMAA_SIZE_16) ? orig : eff;
						next_cur.last_size = cmd_size;
						next_cur.mem_req = 1'b1;
						next_cur.mem_we = (cmd_code == DMAA_CMD_WRITE) ||
							(cmd_code == DMAA_CMD_FILL);
						next_cur.mem_addr = eff;
						next_cur.mem_lane_en = lanes;
						next_cur.mem_wdata = wd;
						next_cur.rd_lane = eff[1:0];
						next_cur.rd_size = cmd_size;
						next_cur.rsp_addr = eff;
						next_cur.state = DMAA_DONE;
					end
				end
			end
			DMAA_DONE: begin
				case (cur.rd_size)
					DMAA_SIZE_32: rd = mem_rdata;
					DMAA_SIZE_16: rd = 32'(16'(mem_rdata >> (5'(2'h2 - cur.rd_lane) << 3)));
					default:      rd = 32'(8'(mem_rdata >> (5'(2'h3 - cur.rd_lane) << 3)));
				endcase
				next_cur.rsp_valid = 1'b1;
				next_cur.rsp_data = cur.mem_we ? 32'h00000000 : rd;
				next_cur.state = DMAA_IDLE;
			end
			default: begin
				next_cur.state = DMAA_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur <= '{state: DMAA_IDLE, last_addr: DMAA_ADDR_RESET, last_size: DMAA_SIZE_8,
				default: '0};
		end else begin
			cur <= next_cur;
		end
	end

	assign mem_req     = cur.mem_req;
	assign mem_we      = cur.mem_we;
	assign mem_addr    = cur.mem_addr;
	assign mem_lane_en = cur.mem_lane_en;
	assign mem_wdata   = cur.mem_wdata;
	assign rsp_valid   = cur.rsp_valid;
	assign rsp_data    = cur.rsp_data;
	assign rsp_addr    = cur.rsp_addr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking dmaa_cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	AST_TRACE_ZERO: assert property (
		cur.state == DMAA_IDLE && cmd_valid && cmd_code == DMAA_CMD_TRACE
		|=> rsp_valid && rsp_data == 32'h00000000 && !mem_req)
		else $error("Trace readout did not answer zero.");

	AST_BLOCK_INC: assert property (
		cur.state == DMAA_IDLE && cmd_valid && cmd_code == DMAA_CMD_DUMP &&
		cmd_size == DMAA_SIZE_8
		|=> mem_addr == $past(cur.last_addr) + dmaa_bytes($past(cur.last_size)))
		else $error("Block byte address not previous plus size.");

	AST_LONG_ALIGN: assert property (
		mem_req && mem_lane_en == 4'hf |-> mem_addr[1:0] == 2'h0)
		else $error("Longword access not aligned.");

	AST_WORD_ORIG: assert property (
		cur.state == DMAA_IDLE && cmd_valid && cmd_size == DMAA_SIZE_16 &&
		(cmd_code == DMAA_CMD_READ || cmd_code == DMAA_CMD_WRITE)
		|=> cur.last_addr == $past(cmd_addr))
		else $error("Word increment base is not original address.");

	AST_WORD_UPPER: assert property (
		cur.state == DMAA_IDLE && cmd_valid && cmd_size == DMAA_SIZE_16 &&
		(cmd_code == DMAA_CMD_READ || cmd_code == DMAA_CMD_WRITE) && cmd_addr[1:0] == 2'h3
		|=> mem_lane_en == 4'hc && mem_addr[1:0] == 2'h2)
		else $error("Word at lane three not realigned.");

	AST_BYTE_LANE: assert property (
		cur.state == DMAA_IDLE && cmd_valid && cmd_size == DMAA_SIZE_8 &&
		(cmd_code == DMAA_CMD_READ || cmd_code == DMAA_CMD_WRITE)
		|=> mem_lane_en == (4'h1 << $past(cmd_addr[1:0])))
		else $error("Byte lane does not follow address.");

	AST_RSP_NEXT: assert property (
		mem_req |=> rsp_valid && !mem_req)
		else $error("Access answer not one cycle after request.");

	AST_LONG_MSB: assert property (
		mem_req && mem_we && mem_lane_en == 4'hf |-> mem_wdata == $past(cmd_wdata))
		else $error("Longword data lanes reordered.");

	COV_TRACE: cover property (cmd_valid && cmd_code == DMAA_CMD_TRACE ##1 rsp_valid);
	COV_WORD_RE: cover property (mem_req && mem_lane_en == 4'hc && cur.last_addr[1:0] == 2'h3);
	COV_DUMP: cover property (cmd_valid && cmd_code == DMAA_CMD_DUMP ##2 rsp_valid);
	COV_FILL32: cover property (mem_req && mem_we && mem_lane_en == 4'hf);

endmodule : dmaa_align

// ==== test/dmaa_mem_model.sv ====
// Memory model that answers the block's lane requests.
module dmaa_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        mem_req,
	input  wire logic [23:0] mem_addr,
	output logic      [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] last = 32'h0;

	// Outside a request the lanes show the inverse of the last word, never a stale copy.
	assign mem_rdata = mem_req ? {mem_addr[9:2], ~mem_addr[9:2], mem_addr[9:2] ^ 8'h5a, 8'hc3}
		: ~last;

	// Remember the last word driven.
	always @(posedge sys_clk) begin
		last <= mem_rdata;
	end
endmodule : dmaa_mem_model

// ==== test/tb.sv ====
// Testbench for the debug memory access alignment block.
module tb import dmaa_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [2:0] c; logic [1:0] s; logic [23:0] a; logic [31:0] d;
		logic [23:0] ea; logic [3:0] el;
	} dmaa_row_t;
	logic        sys_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, mem_req, mem_we, rsp_valid;
	logic [2:0]  cmd_code = 3'h0;
	logic [1:0]  cmd_size = 2'h0;
	logic [23:0] cmd_addr = 24'h0, mem_addr, rsp_addr;
	logic [31:0] cmd_wdata = 32'h0, mem_rdata, mem_wdata, rsp_data;
	logic [3:0]  mem_lane_en;
	int          fails = 0, num_checks = 0;
	// Sequence chained through the block address; each block row depends on the one before.
	dmaa_row_t rows[12] = '{
		'{3'h0, 2'h2, 24'h004003, 32'h0, 24'h004000, 4'hf},
		'{3'h2, 2'h2, 24'h0, 32'h0, 24'h004004, 4'hf},
		'{3'h2, 2'h1, 24'h0, 32'h0, 24'h004008, 4'h3},
		'{3'h2, 2'h1, 24'h0, 32'h0, 24'h00400a, 4'hc},
		'{3'h2, 2'h0, 24'h0, 32'h0, 24'h00400c, 4'h1},
		'{3'h2, 2'h1, 24'h0, 32'h0, 24'h00400d, 4'h6},
		'{3'h2, 2'h1, 24'h0, 32'h0, 24'h00400e, 4'hc},
		'{3'h2, 2'h1, 24'h0, 32'h0, 24'h004011, 4'h6},
		'{3'h1, 2'h0, 24'h002003, 32'hab, 24'h002003, 4'h8},
		'{3'h3, 2'h1, 24'h0, 32'h1234, 24'h002004, 4'h3},
		'{3'h1, 2'h1, 24'h003003, 32'h5678, 24'h003002, 4'hc},
		'{3'h3, 2'h2, 24'h0, 32'h89abcdef, 24'h003004, 4'hf}};

	dmaa_align u_dut (
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.cmd_valid   (cmd_valid),
		.cmd_code    (cmd_code),
		.cmd_size    (cmd_size),
		.cmd_addr    (cmd_addr),
		.cmd_wdata   (cmd_wdata),
		.mem_rdata   (mem_rdata),
		.mem_req     (mem_req),
		.mem_we      (mem_we),
		.mem_addr    (mem_addr),
		.mem_lane_en (mem_lane_en),
		.mem_wdata   (mem_wdata),
		.rsp_valid   (rsp_valid),
		.rsp_data    (rsp_data),
		.rsp_addr    (rsp_addr)
	);
	dmaa_mem_model u_mem (.sys_clk(sys_clk), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata));

	always #10 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// Issue one command and check both answer cycles.
	task automatic run(input dmaa_row_t r);
		int sh;
		logic [31:0] m;
		logic [31:0] rx;
		logic w;
		sh = (4 - int'(r.ea[1:0]) - (1 << r.s)) * 8;
		m = 32'h0;
		w = r.c[0];
		for (int i = 0; i < 4; i++) if (r.el[i]) m[31 - 8 * i -: 8] = 8'hff;
		rx = ({r.ea[9:2], ~r.ea[9:2], r.ea[9:2] ^ 8'h5a, 8'hc3} & m) >> sh;
		@(posedge sys_clk) #1;
		{cmd_valid, cmd_code, cmd_size, cmd_addr, cmd_wdata} = {1'b1, r.c, r.s, r.a, r.d};
		@(posedge sys_clk) #1;
		// The request pulse stands only in the cycle after the command edge.
		cmd_valid = 1'b0;
		chk(32'(mem_req), 32'h1);
		chk(32'(mem_we), 32'(w));
		chk(32'(mem_addr), 32'(r.ea));
		chk(32'(mem_lane_en), 32'(r.el));
		if (w) chk(mem_wdata & m, (r.d << sh) & m);
		@(posedge sys_clk) #1;
		chk(32'(rsp_valid), 32'h1);
		chk(32'(rsp_addr), 32'(r.ea));
		chk(rsp_data, w ? 32'h0 : rx);
	endtask : run

	// Main sequence; the first row is an addressed read.
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 rstn = 1'b1;
		foreach (rows[i]) run(rows[i]);
		$display("row table done");
		@(posedge sys_clk) #1;
		{cmd_valid, cmd_code} = {1'b1, DMAA_CMD_TRACE};
		@(posedge sys_clk) #1;
		cmd_valid = 1'b0;
		chk(32'(rsp_valid), 32'h1);
		chk(rsp_data, 32'(DMAA_TRACE_VALUE));
		chk(32'(mem_req), 32'h0);
		$display("trace test done");
		// An unused command code must be ignored without any answer.
		@(posedge sys_clk) #1;
		{cmd_valid, cmd_code} = {1'b1, 3'h5};
		@(posedge sys_clk) #1;
		cmd_valid = 1'b0;
		chk(32'({mem_req, rsp_valid}), 32'h0);
		$display("refused code test done");
		rstn = 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(32'({mem_req, rsp_valid, mem_lane_en, mem_addr}), 32'h0);
		chk(32'({mem_we, rsp_addr}), 32'h0);
		chk(mem_wdata, 32'h0);
		chk(rsp_data, 32'h0);
		#1 rstn = 1'b1;
		run('{3'h2, 2'h0, 24'h0, 32'h0, 24'h000001, 4'h2});
		$display("reset test done");
		test_done();
	end

	// Watchdog well past the expected run length.
	initial begin
		#20us;
		fails++;
		test_done();
	end
endmodule : tb
